/* File: wdt_pkg.sv */
// package: watchdog register layout, reset values and timing constants
package wdt_pkg;
  // register map
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_CONFIG = 4'h2;
  // control field positions
  localparam int SYSCLK_KEEP_BIT = 7;
  localparam int TSEL_LSB = 4;
  localparam int KEY_LSB = 0;
  // reset values and key codes
  localparam logic [7:0] CONTROL_RESET = 8'h7A;
  localparam logic [3:0] KEY_DISABLE = 4'hA;
  localparam logic [3:0] KEY_RECOMMENDED = 4'h5;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // config field positions
  localparam int CFG_WDT_DISABLE_BIT = 0;
  localparam int CFG_DUAL_CLEAR_BIT = 1;
  localparam int CFG_SRC_SYS_BIT = 2;
  localparam int CFG_PIN_RESET_BIT = 3;
  localparam int CFG_LVR_EN_BIT = 4;
  // counter sizing
  localparam int CNT_W = 15;
  localparam int BASE_SHIFT = 8;
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int RESET_DELAY_MS = 100;
  localparam int RESET_DELAY_CYCLES = CLK_HZ / 1000 * RESET_DELAY_MS;
  localparam int LVR_MIN_US = 1;
  localparam int LVR_MIN_CYCLES = (CLK_HZ / 1_000_000) * LVR_MIN_US;
  // instruction events into the block
  typedef struct packed {
    logic clr_single;
    logic clr_first;
    logic clr_second;
    logic halt;
  } wdt_cmd_t;
  // operating mode
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_IDLE,
    MODE_IDLE_CLOCK_OFF,
    MODE_SLEEP
  } cpu_mode_t;
endpackage

/* File: sync2.sv */
// two-flop synchroniser for one level
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in and out
  input wire logic d,
  output logic q
);
  logic meta_q;
  // first flop read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: hold_timer.sv */
// counter that reports a condition held for a least number of cycles
`timescale 1ns/100ps
`default_nettype none
module hold_timer #(
  parameter int COUNT = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // condition and result
  input wire logic cond,
  output logic held
);
  localparam int W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LIMIT = W'(COUNT);
  logic [W-1:0] cnt_q;
  // count while the condition stands, restart when it drops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (!cond) begin
      cnt_q <= '0;
    end else if (cnt_q != LIMIT) begin
      cnt_q <= cnt_q + W'(1);
    end
  end
  assign held = (cnt_q == LIMIT);
endmodule
`default_nettype wire

/* File: wdt_reset_ctrl.sv */
// watchdog timer with control register and reset sources
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module wdt_reset_ctrl
  import wdt_pkg::*;
#(
  parameter int DELAY_CYCLES = RESET_DELAY_CYCLES
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // cpu events, mode and clock ticks
  input wire wdt_cmd_t cmd,
  input wire cpu_mode_t mode,
  input wire logic sub_clock_tick,
  input wire logic sys_div4_tick,
  // pins and analog monitor
  input wire logic external_reset_pin,
  input wire logic low_supply,
  // reset, flag and control outputs
  output logic device_reset,
  output logic pc_sp_reset,
  output logic cpu_hold,
  output logic port_preset,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic idle_sysclk_keep
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic pin_s, sub_s, low_s;
  sync2 #(.INIT(1'b1)) u_pin (.clk(clk), .rst(rst),
    .d(external_reset_pin), .q(pin_s));
  sync2 #(.INIT(1'b0)) u_sub (.clk(clk), .rst(rst),
    .d(sub_clock_tick), .q(sub_s));
  sync2 #(.INIT(1'b0)) u_low (.clk(clk), .rst(rst),
    .d(low_supply), .q(low_s));

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] control_q, config_q;
  logic to_q, pdf_q;
  logic [3:0] key;
  logic [2:0] tsel;
  logic cfg_off, cfg_dual, cfg_sys, cfg_pin, cfg_lvr;
  assign key = control_q[KEY_LSB +: 4];
  assign tsel = control_q[TSEL_LSB +: 3];
  assign cfg_off = config_q[CFG_WDT_DISABLE_BIT];
  assign cfg_dual = config_q[CFG_DUAL_CLEAR_BIT];
  assign cfg_sys = config_q[CFG_SRC_SYS_BIT];
  assign cfg_pin = config_q[CFG_PIN_RESET_BIT];
  assign cfg_lvr = config_q[CFG_LVR_EN_BIT];

  // reset source detection
  logic pin_low, lvr_held, ext_reset;
  assign pin_low = cfg_pin && !pin_s;
  hold_timer #(.COUNT(LVR_MIN_CYCLES)) u_lvr (.clk(clk), .rst(rst),
    .cond(low_s && cfg_lvr), .held(lvr_held));
  assign ext_reset = pin_low || lvr_held;

  // watchdog enable: off only with option and key 1010
  logic wdt_en;
  assign wdt_en = !(cfg_off && key == KEY_DISABLE);

  // control and config writes; power-on value holds key 1010
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control_q <= CONTROL_RESET;
      config_q <= CONFIG_RESET;
    end else if (wr && addr == ADDR_CONTROL) begin
      control_q <= wdata;
    end else if (wr && addr == ADDR_CONFIG) begin
      config_q <= wdata;
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        ADDR_CONTROL: rdata <= control_q;
        ADDR_STATUS: rdata <= {6'h00, pdf_q, to_q};
        ADDR_CONFIG: rdata <= config_q;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // software clear decode
  // ----------------------------------------------------------------
  logic last_second_q, last_valid_q;
  logic sw_clear;
  always_comb begin
    sw_clear = 1'b0;
    if (wdt_en) begin
      if (!cfg_dual) begin
        sw_clear = cmd.clr_single;
      end else begin
        sw_clear = (cmd.clr_first && (!last_valid_q || last_second_q)) ||
                   (cmd.clr_second && (!last_valid_q || !last_second_q));
      end
    end
  end

  // remember which dual clear ran last
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_valid_q <= 1'b0;
      last_second_q <= 1'b0;
    end else if (wdt_en && cfg_dual && sw_clear) begin
      last_valid_q <= 1'b1;
      last_second_q <= cmd.clr_second;
    end
  end

  // ----------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] limit;
  logic sub_prev_q;
  logic tick, src_stopped, overflow;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sub_prev_q <= 1'b0;
    end else begin
      sub_prev_q <= sub_s;
    end
  end
  // source select and stop of sys/4 in sleep or idle_clock_off_mode
  assign src_stopped = cfg_sys && (mode == MODE_SLEEP ||
                       mode == MODE_IDLE_CLOCK_OFF);
  assign tick = cfg_sys ? (sys_div4_tick && !src_stopped)
                        : (sub_s && !sub_prev_q);
  assign limit = CNT_W'((32'd1 << (BASE_SHIFT + 32'(tsel))) - 32'd1);
  assign overflow = wdt_en && tick && cnt_q == limit;

  // clears: reset, pin or lvr, cpu hold, software, halt, overflow
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (ext_reset || cpu_hold || sw_clear || cmd.halt) begin
      cnt_q <= '0;
    end else if (overflow) begin
      cnt_q <= '0;
    end else if (wdt_en && tick) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic asleep;
  assign asleep = mode != MODE_NORMAL;
  // overflow sets timeout_flag; set wins over clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      to_q <= 1'b0;
    end else if (overflow) begin
      to_q <= 1'b1;
    end else if (cmd.halt || sw_clear) begin
      to_q <= 1'b0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pdf_q <= 1'b0;
    end else if (cmd.halt) begin
      pdf_q <= 1'b1;
    end else if (sw_clear) begin
      pdf_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // reset outputs
  // ----------------------------------------------------------------
  // full reset on pin, lvr or normal overflow; pc/sp only asleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      device_reset <= 1'b1;
      pc_sp_reset <= 1'b0;
    end else begin
      device_reset <= ext_reset || (overflow && !asleep);
      pc_sp_reset <= overflow && asleep;
    end
  end

  // start-up delay counter after reset release
  localparam int DW = $clog2(DELAY_CYCLES + 1);
  logic [DW-1:0] delay_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delay_q <= DW'(DELAY_CYCLES);
    end else if (ext_reset || (overflow && !asleep)) begin
      delay_q <= DW'(DELAY_CYCLES);
    end else if (delay_q != '0) begin
      delay_q <= delay_q - DW'(1);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_hold <= 1'b1;
    end else begin
      cpu_hold <= ext_reset || delay_q > DW'(1) ||
                  (overflow && !asleep);
    end
  end

  // port registers preset high during power-on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_preset <= 1'b1;
    end else begin
      port_preset <= ext_reset;
    end
  end

  // flag and control outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
      idle_sysclk_keep <= 1'b0;
    end else begin
      timeout_flag <= to_q;
      powerdown_flag <= pdf_q;
      idle_sysclk_keep <= control_q[SYSCLK_KEEP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_disabled_no_clear: assert property (@(posedge clk) disable iff (rst)
    (cfg_off && key == KEY_DISABLE) |-> !sw_clear)
    else $error("clear accepted while watchdog disabled");
  a_overflow_normal_reset: assert property (@(posedge clk)
    disable iff (rst) (overflow && !asleep) |=> device_reset && to_q)
    else $error("normal overflow without full reset");
  a_overflow_sleep_pcsp: assert property (@(posedge clk) disable iff (rst)
    (overflow && asleep && !ext_reset) |=> pc_sp_reset && !device_reset
    && to_q)
    else $error("sleep overflow handled wrongly");
  a_dual_repeat_ignored: assert property (@(posedge clk) disable iff (rst)
    (cfg_dual && last_valid_q && last_second_q && cmd.clr_second &&
     !cmd.clr_first) |-> !sw_clear)
    else $error("repeated second clear accepted");
  a_stopped_no_count: assert property (@(posedge clk) disable iff (rst)
    (src_stopped && !cmd.halt && !ext_reset && !sw_clear && !cpu_hold)
    |=> cnt_q == $past(cnt_q))
    else $error("counter moved with sys clock stopped");
  a_pin_clears_count: assert property (@(posedge clk) disable iff (rst)
    pin_low |=> cnt_q == '0 && device_reset)
    else $error("pin low did not clear counter");
  a_pin_option_off: assert property (@(posedge clk) disable iff (rst)
    !cfg_pin |-> !pin_low)
    else $error("reset pin acted with option off");
  a_overflow_pulse: assert property (@(posedge clk) disable iff (rst)
    overflow |=> cnt_q == '0 && !overflow)
    else $error("overflow not one cycle");
  a_hold_after_pin: assert property (@(posedge clk) disable iff (rst)
    $fell(pin_low) && !lvr_held |=> cpu_hold [*2])
    else $error("cpu released too early after pin");
  a_power_key: assert property (@(posedge clk)
    $fell(rst) |-> key == KEY_DISABLE)
    else $error("key not 1010 after power-on");

  // ----------------------------------------------------------------
  // further checks on enable, clears and outputs
  // ----------------------------------------------------------------
  // a disabled watchdog never times out
  a_disabled_no_overflow: assert property (@(posedge clk) disable iff (rst)
    !wdt_en |-> !overflow)
    else $error("overflow while watchdog disabled");

  // repeated first clear is ignored as well
  a_dual_first_repeat: assert property (@(posedge clk) disable iff (rst)
    (cfg_dual && last_valid_q && !last_second_q && cmd.clr_first &&
     !cmd.clr_second) |-> !sw_clear)
    else $error("repeated first clear accepted");

  // halt always clears the counter
  a_halt_clears_count: assert property (@(posedge clk) disable iff (rst)
    cmd.halt |=> cnt_q == '0)
    else $error("halt did not clear counter");

  // sleep time-out request lasts one cycle
  a_pcsp_one_cycle: assert property (@(posedge clk) disable iff (rst)
    pc_sp_reset |=> !pc_sp_reset)
    else $error("pc and sp reset longer than one cycle");

  // pin or supply reset presets the ports
  a_port_preset_ext: assert property (@(posedge clk) disable iff (rst)
    ext_reset |=> port_preset && device_reset)
    else $error("external reset without port preset");

  // idle clock keep follows control bit 7
  a_sysclk_keep_copy: assert property (@(posedge clk) disable iff (rst)
    $rose(control_q[SYSCLK_KEEP_BIT]) |=> idle_sysclk_keep)
    else $error("idle clock keep not following control");

  // read data are zero unless a read was made
  a_rdata_idle_zero: assert property (@(posedge clk) disable iff (rst)
    !rd |=> rdata == 8'h00)
    else $error("read data present without read");
endmodule
`default_nettype wire

/* File: test_wdt_reset_ctrl.sv */
// testbench: watchdog, control register and reset sources
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  n_errors++; $display("CHECK FAILED at %0t: got %0h exp %0h", \
  $time, got, exp); end end
module test_wdt_reset_ctrl;
  import wdt_pkg::*;
  // ---------------------------------------------------------------
  // signals and design
  // ---------------------------------------------------------------
  localparam int DLY = 20;
  localparam logic [3:0] CMD_SINGLE = 4'h8;
  localparam logic [3:0] CMD_FIRST = 4'h4;
  localparam logic [3:0] CMD_SECOND = 4'h2;
  localparam logic [3:0] CMD_HALT = 4'h1;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  wdt_cmd_t cmd = '0;
  cpu_mode_t mode = MODE_NORMAL;
  logic sys_div4_tick = 1'b0;
  logic sub_clock_tick = 1'b0;
  logic external_reset_pin = 1'b1;
  logic low_supply = 1'b0;
  logic device_reset, pc_sp_reset, cpu_hold, port_preset;
  logic timeout_flag, powerdown_flag, idle_sysclk_keep;
  int n_errors = 0;
  int tests_run = 0;
  int tk, at, dev_n, pcsp_n;

  wdt_reset_ctrl #(.DELAY_CYCLES(DLY)) wdt_reset_ctrl_i (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cmd(cmd), .mode(mode), .sub_clock_tick(sub_clock_tick),
    .sys_div4_tick(sys_div4_tick),
    .external_reset_pin(external_reset_pin), .low_supply(low_supply),
    .device_reset(device_reset), .pc_sp_reset(pc_sp_reset),
    .cpu_hold(cpu_hold), .port_preset(port_preset),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
    .idle_sysclk_keep(idle_sysclk_keep)
  );

  // clock and reset-request cycle counters
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (!rst && device_reset) dev_n++;
    if (!rst && pc_sp_reset) pcsp_n++;
  end

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, exp)
  endtask

  task automatic pulse(input logic [3:0] c);
    @(posedge clk);
    cmd <= wdt_cmd_t'(c);
    @(posedge clk);
    cmd <= '0;
  endtask

  // count ticks; note the tick number of the first reset request
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      sys_div4_tick <= 1'b1;
      @(posedge clk);
      sys_div4_tick <= 1'b0;
      @(posedge clk);
      tk++;
      #1;
      if (at == 0 && dev_n + pcsp_n > 0) at = tk;
    end
  endtask

  // load options and control, clear the counter with halt
  task automatic setup(input logic [7:0] cfg, input logic [7:0] ctl);
    wr_reg(ADDR_CONFIG, cfg);
    wr_reg(ADDR_CONTROL, ctl);
    pulse(CMD_HALT);
    repeat (2) @(posedge clk);
    tk = 0;
    at = 0;
    dev_n = 0;
    pcsp_n = 0;
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    #1;
    `CHK(port_preset, 1'b1)
    `CHK(cpu_hold, 1'b1)
    rst = 1'b0;
    repeat (DLY / 2) @(posedge clk);
    #1;
    `CHK(cpu_hold, 1'b1)
    `CHK(port_preset, 1'b0)
    rd_reg(ADDR_CONTROL, 8'h7A);
    rd_reg(ADDR_CONFIG, CONFIG_RESET);
    rd_reg(4'h5, 8'h00);
    repeat (DLY) @(posedge clk);
    #1;
    `CHK(cpu_hold, 1'b0)
    `CHK(idle_sysclk_keep, 1'b0)
    wr_reg(ADDR_CONTROL, 8'h85);
    @(posedge clk);
    #1;
    `CHK(idle_sysclk_keep, 1'b1)
    // overflow count for the first time-out selections
    for (int t = 0; t < 3; t++) begin
      setup(8'h04, {1'b0, 3'(t), KEY_RECOMMENDED});
      `CHK(powerdown_flag, 1'b1)
      tick((256 << t) + 4);
      `CHK(at, 256 << t)
      `CHK(dev_n, 1)
      `CHK(timeout_flag, 1'b1)
      rd_reg(ADDR_STATUS, 8'h03);
    end
    // single clear restarts the count
    setup(8'h04, 8'h05);
    tick(200);
    pulse(CMD_SINGLE);
    tick(260);
    `CHK(at, 456)
    // dual clear: a repeated second clear is ignored
    setup(8'h06, 8'h05);
    pulse(CMD_FIRST);
    tick(200);
    pulse(CMD_SECOND);
    tick(200);
    pulse(CMD_SECOND);
    tick(60);
    `CHK(at, 456)
    // disable needs both option and key
    setup(8'h05, 8'h0A);
    tick(300);
    `CHK(at, 0)
    setup(8'h05, 8'h05);
    tick(300);
    `CHK(at, 256)
    // idle time-out resets only pc and sp
    mode <= MODE_IDLE;
    setup(8'h04, 8'h05);
    tick(300);
    `CHK(pcsp_n, 1)
    `CHK(dev_n, 0)
    `CHK(timeout_flag, 1'b1)
    // sys/4 source halts in sleep and idle clock-off
    mode <= MODE_SLEEP;
    setup(8'h04, 8'h05);
    tick(300);
    `CHK(at, 0)
    mode <= MODE_IDLE_CLOCK_OFF;
    setup(8'h04, 8'h05);
    tick(300);
    `CHK(at, 0)
    mode <= MODE_NORMAL;
    // sub clock source: sys/4 ticks ignored, 256 slow edges overflow
    setup(8'h00, 8'h05);
    tick(300);
    `CHK(at, 0)
    repeat (256) begin
      @(posedge clk);
      sub_clock_tick <= 1'b1;
      repeat (2) @(posedge clk);
      sub_clock_tick <= 1'b0;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    #1;
    `CHK(dev_n, 1)
    // reset pin ignored unless the option selects it
    setup(8'h00, 8'h05);
    external_reset_pin <= 1'b0;
    repeat (10) @(posedge clk);
    external_reset_pin <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    `CHK(dev_n, 0)
    setup(8'h08, 8'h05);
    external_reset_pin <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    `CHK(device_reset, 1'b1)
    `CHK(port_preset, 1'b1)
    `CHK(cpu_hold, 1'b1)
    external_reset_pin <= 1'b1;
    repeat (DLY / 2) @(posedge clk);
    #1;
    `CHK(cpu_hold, 1'b1)
    repeat (DLY + 4) @(posedge clk);
    #1;
    `CHK(cpu_hold, 1'b0)
    // short supply dip ignored, long one resets
    setup(8'h10, 8'h05);
    low_supply <= 1'b1;
    repeat (10) @(posedge clk);
    low_supply <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    `CHK(dev_n, 0)
    low_supply <= 1'b1;
    repeat (LVR_MIN_CYCLES + 10) @(posedge clk);
    #1;
    `CHK(device_reset, 1'b1)
    low_supply <= 1'b0;
    repeat (DLY + 10) @(posedge clk);
    summarize();
  end

  // watchdog against a hang
  initial begin
    #(40 * 40000);
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
